// ==== core/lpt_translator.sv ====
// linear to physical page translator with apb control registers
// Notes on behaviour
// - paging_enable is bit 31 of control_word_zero; set turns translation on.
// - large_page_enable is bit 4 of control_word_four.
// - address_extension_enable is bit 5 of control_word_four.
// - extension widens physical addresses to 36 bits, only while paging.
// - large pages: 4 MB, or 2 MB with extension; otherwise 4 KB.
// - feature register bit 17 reports the wide large-page feature.
// - directory: 1024 entries of 32 bits in one 4 KB page.
// - table: 1024 entries of 32 bits; unused for large pages.
// - extension uses a top table of four 64-bit directory pointers.
// - page_size_select 0 means table; 1 means large page.
// - wide feature lets 4 MB entries reach 36-bit addresses.
// - 4 KB walk: linear bits 31..22 index the directory.
// - 4 KB walk: linear bits 21..12 index the table.
// - 4 KB walk: linear bits 11..0 are the page offset.
// - 4 MB page: directory entry gives base directly, no table read.
// - 4 MB page: linear bits 21..0 are the page offset.
// - plain mode limits 4 KB page addresses to 4 GB; wide 4 MB pages reach 36 bits.
// - more than 36 bits only where supported; this core has 36.
// - large_page_enable clear without extension: every directory entry locates a table.
// - a clear present bit in any walked entry raises a page fault.
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps
`include "lpt_map.svh"

module lpt_translator
	import lpt_pkg::*;
(
	input  wire logic                sys_clk,
	input  wire logic                rst_b,
	input  wire logic                ce,
	// apb slave
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	input  wire logic [3:0]          pstrb,
	output logic [31:0]              prdata,
	output logic                     pready,
	output logic                     pslverr,
	// translation request
	input  wire logic                reqValid,
	input  wire logic [31:0]         reqLinear,
	output logic                     reqReady,
	output logic                     respValid,
	output logic [`LPT_PA_W-1:0]     respPhys,
	output logic                     respFault,
	output lpt_size_t                respSize,
	// table memory reads
	output logic                     memReq,
	output logic                     memWide,
	output logic [`LPT_PA_W-1:0]     memAddr,
	input  wire logic                memAck,
	input  wire logic [63:0]         memData
);

	lpt_state_t              state;
	lpt_state_t              next_state;
	logic [31:0]             ctlZero;
	logic [31:0]             ctlFour;
	logic [`LPT_PA_W-1:0]    dirBase;
	logic [31:0]             linLatch;
	logic                    modeExt;
	logic                    modeLarge;
	logic [`LPT_PA_W-1:0]    lastPhys;
	logic                    lastFault;
	lpt_size_t               lastSize;

	wire logic               pagingOn;
	wire logic               largeOn;
	wire logic               extOn;
	wire logic               apbAccess;
	wire logic               apbWrite;
	wire logic               apbHit;
	wire logic [31:0]        apbRdata;
	wire logic [31:0]        featureWord;
	wire logic [31:0]        statusWord;
	wire logic               reqTake;
	wire logic               ackTake;
	wire logic [31:0]        linSel;
	wire logic [63:0]        entryW;
	wire logic               entryHere;
	wire logic               entryLarge;
	wire logic               toTable;
	wire logic               walkExt;
	wire logic [23:0]        nextBase;
	wire logic [`LPT_PA_W-1:0] nextAddr;
	wire logic [`LPT_PA_W-1:0] physOut;
	wire logic [`LPT_PA_W-1:0] ptrAddr;
	lpt_size_t               pageSize;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] laneMerge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return res;
	endfunction

	function automatic logic isOffset(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction

	// ----------------------------------------------------------------
	// mode flags
	// ----------------------------------------------------------------
	assign pagingOn = ctlZero[`LPT_BIT_PAGING];
	assign largeOn  = ctlFour[`LPT_BIT_LARGE];
	assign extOn    = ctlFour[`LPT_BIT_EXTEND];

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	assign apbAccess = psel && penable && pready;
	assign apbWrite  = apbAccess && pwrite && apbHit;
	assign apbHit = isOffset(paddr, `LPT_OFS_CTLZERO) || isOffset(paddr, `LPT_OFS_CTLFOUR)
		|| isOffset(paddr, `LPT_OFS_DIRLO) || isOffset(paddr, `LPT_OFS_DIRHI)
		|| isOffset(paddr, `LPT_OFS_FEATURE) || isOffset(paddr, `LPT_OFS_STATUS)
		|| isOffset(paddr, `LPT_OFS_PHYSLO) || isOffset(paddr, `LPT_OFS_PHYSHI);

	// feature word as reported for query input 1
	assign featureWord = {14'h0, `LPT_WIDE_FEATURE, 17'h0};
	assign statusWord = {26'h0, pagingOn && extOn, pagingOn, lastSize, lastFault,
		state != LPT_IDLE};

	assign apbRdata =
		isOffset(paddr, `LPT_OFS_CTLZERO) ? ctlZero :
		isOffset(paddr, `LPT_OFS_CTLFOUR) ? ctlFour :
		isOffset(paddr, `LPT_OFS_DIRLO)   ? dirBase[31:0] :
		isOffset(paddr, `LPT_OFS_DIRHI)   ? {28'h0, dirBase[35:32]} :
		isOffset(paddr, `LPT_OFS_FEATURE) ? featureWord :
		isOffset(paddr, `LPT_OFS_STATUS)  ? statusWord :
		isOffset(paddr, `LPT_OFS_PHYSLO)  ? lastPhys[31:0] :
		isOffset(paddr, `LPT_OFS_PHYSHI)  ? {28'h0, lastPhys[35:32]} : 32'h0;

	// ----------------------------------------------------------------
	// apb slave: one wait state, answer on the second access cycle
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			pready  <= 1'b0;
			prdata  <= 32'h0;
			pslverr <= 1'b0;
		end else if (ce) begin
			pready  <= psel && penable && !pready;
			prdata  <= (psel && penable && !pready && !pwrite) ? apbRdata : 32'h0;
			pslverr <= psel && penable && !pready && !apbHit;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctlZero <= `LPT_RST_CTLZERO;
			ctlFour <= `LPT_RST_CTLFOUR;
			dirBase <= `LPT_RST_DIRBASE;
		end else if (ce && apbWrite) begin
			if (isOffset(paddr, `LPT_OFS_CTLZERO)) begin
				ctlZero <= laneMerge(ctlZero, pwdata, pstrb)
					& (32'h1 << `LPT_BIT_PAGING);
			end
			if (isOffset(paddr, `LPT_OFS_CTLFOUR)) begin
				ctlFour <= laneMerge(ctlFour, pwdata, pstrb)
					& ((32'h1 << `LPT_BIT_LARGE) | (32'h1 << `LPT_BIT_EXTEND));
			end
			if (isOffset(paddr, `LPT_OFS_DIRLO)) begin
				dirBase[31:0] <= laneMerge(dirBase[31:0], pwdata, pstrb);
			end
			if (isOffset(paddr, `LPT_OFS_DIRHI) && pstrb[0]) begin
				dirBase[35:32] <= pwdata[3:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// walk datapath
	// ----------------------------------------------------------------
	assign reqTake = reqValid && reqReady;
	assign ackTake = memReq && memAck;
	assign linSel  = (state == LPT_IDLE) ? reqLinear : linLatch;
	// 32-bit entries sit in the low word outside extended mode
	assign entryW    = modeExt ? memData : {32'h0, memData[31:0]};
	assign entryHere = entryW[`LPT_ENT_PRESENT];
	// size select honoured only under extension or large pages
	assign entryLarge = entryW[`LPT_ENT_SIZESEL] && (modeExt || modeLarge);
	assign toTable  = (state == LPT_DIR);
	// idle start is plain; an extended walk starts at ptrAddr, not the last walk's mode
	assign walkExt  = (state != LPT_IDLE) && modeExt;
	assign nextBase = (state == LPT_IDLE) ? dirBase[35:12] : entryW[35:12];
	assign ptrAddr  = {dirBase[35:5], linSel[31:30], 3'h0};

	always_comb begin
		pageSize = LPT_SZ_NONE;
		if (state == LPT_TBL) begin
			pageSize = LPT_SZ_4K;
		end else if (state == LPT_DIR && entryLarge) begin
			pageSize = modeExt ? LPT_SZ_2M : LPT_SZ_4M;
		end
	end

	lpt_walk_addr u_walk (
		.toTable   (toTable),
		.extMode   (walkExt),
		.wideFeat  (`LPT_WIDE_FEATURE && !modeExt),
		.tableBase (nextBase),
		.linear    (linSel),
		.entry     (entryW),
		.pageSize  (pageSize),
		.entryAddr (nextAddr),
		.physAddr  (physOut)
	);

	// ----------------------------------------------------------------
	// walk sequencer
	// ----------------------------------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			LPT_IDLE: begin
				if (reqTake) begin
					if (!pagingOn) begin
						next_state = LPT_DONE;
					end else if (extOn) begin
						next_state = LPT_PTR;
					end else begin
						next_state = LPT_DIR;
					end
				end
			end
			LPT_PTR: begin
				if (ackTake) begin
					next_state = entryHere ? LPT_DIR : LPT_DONE;
				end
			end
			LPT_DIR: begin
				if (ackTake) begin
					if (!entryHere || entryLarge) begin
						next_state = LPT_DONE;
					end else begin
						next_state = LPT_TBL;
					end
				end
			end
			LPT_TBL: begin
				if (ackTake) begin
					next_state = LPT_DONE;
				end
			end
			LPT_DONE: next_state = LPT_IDLE;
			default:  next_state = LPT_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= LPT_IDLE;
		end else if (ce) begin
			state <= next_state;
		end
	end

	// ----------------------------------------------------------------
	// request capture and table reads
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			linLatch  <= 32'h0;
			modeExt   <= 1'b0;
			modeLarge <= 1'b0;
			memReq    <= 1'b0;
			memWide   <= 1'b0;
			memAddr   <= '0;
			reqReady  <= 1'b0;
		end else if (ce) begin
			reqReady <= (next_state == LPT_IDLE);
			if (state == LPT_IDLE && reqTake) begin
				linLatch  <= reqLinear;
				// widening only while paging is on
				modeExt   <= pagingOn && extOn;
				modeLarge <= pagingOn && largeOn;
				memWide   <= pagingOn && extOn;
				if (pagingOn) begin
					memReq  <= 1'b1;
					memAddr <= extOn ? ptrAddr : nextAddr;
				end
			end else if (ackTake) begin
				memReq <= 1'b0;
				if (entryHere && next_state != LPT_DONE) begin
					memReq   <= 1'b1;
					memAddr  <= nextAddr;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// answer
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			respValid <= 1'b0;
			respPhys  <= '0;
			respFault <= 1'b0;
			respSize  <= LPT_SZ_NONE;
			lastPhys  <= '0;
			lastFault <= 1'b0;
			lastSize  <= LPT_SZ_NONE;
		end else if (ce) begin
			respValid <= 1'b0;
			if (state == LPT_IDLE && reqTake && !pagingOn) begin
				// plain linear pass-through, top bits zero
				respValid <= 1'b1;
				respPhys  <= {4'h0, reqLinear};
				respFault <= 1'b0;
				respSize  <= LPT_SZ_NONE;
				lastPhys  <= {4'h0, reqLinear};
				lastFault <= 1'b0;
				lastSize  <= LPT_SZ_NONE;
			end else if (ackTake && !entryHere) begin
				respValid <= 1'b1;
				respPhys  <= '0;
				respFault <= 1'b1;
				respSize  <= LPT_SZ_NONE;
				lastPhys  <= '0;
				lastFault <= 1'b1;
				lastSize  <= LPT_SZ_NONE;
			end else if (ackTake && pageSize != LPT_SZ_NONE) begin
				// outside extended mode entries are 32 bits: 4 GB unless wide
				respValid <= 1'b1;
				respPhys  <= physOut;
				respFault <= 1'b0;
				respSize  <= pageSize;
				lastPhys  <= physOut;
				lastFault <= 1'b0;
				lastSize  <= pageSize;
			end
		end
	end

endmodule

// ==== core/lpt_map.svh ====
// address map, field positions, reset values and widths of the page translator
`ifndef LPT_MAP_SVH
`define LPT_MAP_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define LPT_OFS_CTLZERO   8'h00
`define LPT_OFS_CTLFOUR   8'h04
`define LPT_OFS_DIRLO     8'h08
`define LPT_OFS_DIRHI     8'h0c
`define LPT_OFS_FEATURE   8'h10
`define LPT_OFS_STATUS    8'h14
`define LPT_OFS_PHYSLO    8'h18
`define LPT_OFS_PHYSHI    8'h1c

// ----------------------------------------------------------------
// control and feature bit positions
// ----------------------------------------------------------------
`define LPT_BIT_PAGING    31
`define LPT_BIT_LARGE     4
`define LPT_BIT_EXTEND    5
`define LPT_BIT_WIDEFEAT  17

// ----------------------------------------------------------------
// entry fields
// ----------------------------------------------------------------
`define LPT_ENT_PRESENT   0
`define LPT_ENT_SIZESEL   7
`define LPT_ENT_WIDEHI    16
`define LPT_ENT_WIDELO    13

// ----------------------------------------------------------------
// widths and reset values
// ----------------------------------------------------------------
`define LPT_PA_W          36
`define LPT_RST_CTLZERO   32'h0000_0000
`define LPT_RST_CTLFOUR   32'h0000_0000
`define LPT_RST_DIRBASE   36'h0_0000_0000
`define LPT_WIDE_FEATURE  1'b1

`endif

// ==== core/lpt_pkg.sv ====
// types shared by the page translator files
package lpt_pkg;

	typedef enum logic [2:0] {
		LPT_IDLE = 3'b000,
		LPT_PTR  = 3'b001,
		LPT_DIR  = 3'b011,
		LPT_TBL  = 3'b010,
		LPT_DONE = 3'b110
	} lpt_state_t;

	typedef enum logic [1:0] {
		LPT_SZ_NONE = 2'h0,
		LPT_SZ_4K   = 2'h1,
		LPT_SZ_2M   = 2'h2,
		LPT_SZ_4M   = 2'h3
	} lpt_size_t;

endpackage

// ==== core/lpt_walk_addr.sv ====
// table entry address and physical address forming
`timescale 1ns/10ps
`include "lpt_map.svh"

module lpt_walk_addr
	import lpt_pkg::*;
(
	input  wire logic               toTable,
	input  wire logic               extMode,
	input  wire logic               wideFeat,
	input  wire logic [23:0]        tableBase,
	input  wire logic [31:0]        linear,
	input  wire logic [63:0]        entry,
	input  wire lpt_size_t          pageSize,
	output logic [`LPT_PA_W-1:0]    entryAddr,
	output logic [`LPT_PA_W-1:0]    physAddr
);

	wire logic [`LPT_PA_W-1:0] dirAddr;
	wire logic [`LPT_PA_W-1:0] tblAddr;
	wire logic [3:0]           wideHi;

	// ----------------------------------------------------------------
	// entry address
	// ----------------------------------------------------------------
	assign dirAddr = extMode ? {tableBase, linear[29:21], 3'h0}
		: {tableBase, linear[31:22], 2'h0};
	assign tblAddr = extMode ? {tableBase, linear[20:12], 3'h0}
		: {tableBase, linear[21:12], 2'h0};
	assign entryAddr = toTable ? tblAddr : dirAddr;

	// ----------------------------------------------------------------
	// physical address
	// ----------------------------------------------------------------
	assign wideHi = wideFeat ? entry[`LPT_ENT_WIDEHI:`LPT_ENT_WIDELO] : 4'h0;

	always_comb begin
		case (pageSize)
			LPT_SZ_4K: physAddr = {entry[35:12], linear[11:0]};
			LPT_SZ_2M: physAddr = {entry[35:21], linear[20:0]};
			LPT_SZ_4M: physAddr = {wideHi, entry[31:22], linear[21:0]};
			default:   physAddr = {4'h0, linear};
		endcase
	end

endmodule

// ==== tb/lpt_monitor.sv ====
// port assertions for the page translator
`timescale 1ns/10ps
`include "lpt_map.svh"

module lpt_monitor
	import lpt_pkg::*;
(
	input wire logic            sys_clk,
	input wire logic            rst_b,
	input wire logic            ce,
	input wire logic            psel,
	input wire logic            penable,
	input wire logic            pwrite,
	input wire logic [7:0]      paddr,
	input wire logic [31:0]     pwdata,
	input wire logic [3:0]      pstrb,
	input wire logic            pready,
	input wire logic            pslverr,
	input wire logic            reqValid,
	input wire logic [31:0]     reqLinear,
	input wire logic            reqReady,
	input wire logic            respValid,
	input wire logic [35:0]     respPhys,
	input wire logic            respFault,
	input wire lpt_size_t       respSize,
	input wire logic            memReq,
	input wire logic            memWide,
	input wire logic [35:0]     memAddr,
	input wire logic            memAck,
	input wire logic [63:0]     memData
);
	// ----------------------------------------------------------------
	// shadow of control flags and walk progress
	// ----------------------------------------------------------------
	logic        pageOn, bigOn, extOn;
	logic [31:0] lin;
	logic [63:0] dat;
	logic [1:0]  stg;
	wire         take = reqValid && reqReady && ce;
	wire         wr = psel && penable && pready && pwrite && ce;
	wire         ack = memReq && memAck && ce;
	wire         dirOk = ack && stg == 2'h0 && pageOn && !extOn && memData[0];
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			{pageOn, bigOn, extOn, lin, dat, stg} <= '0;
		end else begin
			if (wr && paddr == `LPT_OFS_CTLZERO && pstrb[3]) pageOn <= pwdata[31];
			if (wr && paddr == `LPT_OFS_CTLFOUR && pstrb[0]) {extOn, bigOn} <= pwdata[5:4];
			if (take) lin <= reqLinear;
			if (take) stg <= 2'h0;
			else if (ack) stg <= stg + 2'h1;
			if (ack) dat <= memData;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	nopage_pass_a: assert property (take && !pageOn |=> respValid && !memReq
		&& respPhys == {4'h0, lin} && respSize == LPT_SZ_NONE) else $error("paging off bad");
	dir_index_a: assert property (take && pageOn && !extOn |=> memReq && !memWide
		&& memAddr[11:0] == {lin[31:22], 2'b00}) else $error("directory index bad");
	ptr_index_a: assert property (take && pageOn && extOn |=> memReq && memWide
		&& memAddr[4:0] == {lin[31:30], 3'b000}) else $error("pointer index bad");
	tbl_index_a: assert property (dirOk && !(bigOn && memData[7]) |=> memReq
		&& memAddr == {4'h0, dat[31:12], lin[21:12], 2'b00}) else $error("table index bad");
	big_page_a: assert property (dirOk && bigOn && memData[7] |=> respValid
		&& !memReq && respSize == LPT_SZ_4M && respPhys == {dat[16:13], dat[31:22], lin[21:0]})
		else $error("large page bad");
	small_off_a: assert property (respValid && respSize == LPT_SZ_4K |->
		respPhys[11:0] == lin[11:0] && (extOn || respPhys[35:32] == 4'h0))
		else $error("small page offset bad");
	mid_off_a: assert property (respValid && respSize == LPT_SZ_2M |->
		extOn && respPhys[20:0] == lin[20:0]) else $error("mid page offset bad");
	fault_zero_a: assert property (ack && !memData[0] |=> respValid && respFault
		&& respPhys == 36'h0 && respSize == LPT_SZ_NONE) else $error("fault answer bad");
	cover property (respValid && respSize == LPT_SZ_2M);
	cover property (respValid && respSize == LPT_SZ_4M);
	cover property (respValid && respFault);
	cover property (pready && pslverr);
endmodule

bind lpt_translator lpt_monitor mon (.sys_clk(sys_clk), .rst_b(rst_b), .ce(ce), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
	.pready(pready), .pslverr(pslverr), .reqValid(reqValid), .reqLinear(reqLinear),
	.reqReady(reqReady), .respValid(respValid), .respPhys(respPhys),
	.respFault(respFault), .respSize(respSize), .memReq(memReq), .memWide(memWide),
	.memAddr(memAddr), .memAck(memAck), .memData(memData));

// ==== tb/lpt_mem_model.sv ====
// behavioural table memory answering entry reads
`timescale 1ns/10ps

module lpt_mem_model (
	input wire logic          sys_clk,
	input wire logic          rst_b,
	input wire logic          memReq,
	input wire logic          memWide,
	input wire logic [35:0]   memAddr,
	input wire logic [7:0]    delay,
	output logic              memAck,
	output logic [63:0]       memData
);
	logic [63:0] mem [logic [35:0]];
	logic [7:0]  cnt;
	function automatic logic [63:0] ent(input logic [35:0] a, input logic wide);
		logic [63:0] e;
		e = mem.exists(a) ? mem[a] : 64'h0;
		// narrow entries carry junk above bit 31
		return wide ? e : {~e[31:0], e[31:0]};
	endfunction
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			memAck <= 1'b0;
			memData <= 64'h0;
			cnt <= 8'h0;
		end else if (memReq && !memAck && cnt >= delay) begin
			memAck <= 1'b1;
			cnt <= 8'h0;
			memData <= ent(memAddr, memWide);
		end else begin
			memAck <= 1'b0;
			cnt <= (memReq && !memAck) ? cnt + 8'h1 : 8'h0;
			memData <= ~memData;
		end
	end
endmodule

// ==== tb/tb.sv ====
// self-checking bench for the page translator
`timescale 1ns/10ps
`include "lpt_map.svh"

module tb
	import lpt_pkg::*;
;
	typedef struct {
		logic [31:0] c0, c4, lin;
		logic [35:0] ph;
		logic [1:0]  sz;
		logic        f;
	} lpt_row_t;
	localparam logic [31:0] EN = 32'h8000_0000;
	logic sys_clk, rst_b, ce, psel, penable, pwrite, pready, pslverr, err;
	logic reqValid, reqReady, respValid, respFault, memReq, memWide, memAck;
	logic [7:0]  paddr, memDelay;
	logic [31:0] pwdata, prdata, reqLinear, rd;
	logic [3:0]  pstrb;
	logic [35:0] respPhys, memAddr;
	logic [63:0] memData;
	lpt_size_t   respSize;
	lpt_row_t    rows [10];
	int          mismatches, tests_run;

	lpt_translator uut (.sys_clk(sys_clk), .rst_b(rst_b), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .reqValid(reqValid),
		.reqLinear(reqLinear), .reqReady(reqReady), .respValid(respValid),
		.respPhys(respPhys), .respFault(respFault), .respSize(respSize), .memReq(memReq),
		.memWide(memWide), .memAddr(memAddr), .memAck(memAck), .memData(memData));
	lpt_mem_model mdl (.sys_clk(sys_clk), .rst_b(rst_b), .memReq(memReq),
		.memWide(memWide), .memAddr(memAddr), .delay(memDelay), .memAck(memAck),
		.memData(memData));

	always #50 sys_clk = ~sys_clk;

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		@(posedge sys_clk);
		{psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, s};
		@(posedge sys_clk);
		penable <= 1'b1;
		// wait states come from the slave; only the watchdog ends a hang
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task automatic xlate(input logic [31:0] l);
		@(posedge sys_clk);
		reqValid <= 1'b1;
		reqLinear <= l;
		do begin
			@(posedge sys_clk);
		end while (reqReady !== 1'b1);
		reqValid <= 1'b0;
		do begin
			@(posedge sys_clk);
		end while (respValid !== 1'b1);
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	initial begin
		{sys_clk, rst_b, psel, penable, pwrite, reqValid} = '0;
		ce = 1'b1;
		{paddr, pwdata, pstrb, reqLinear, memDelay} = '0;
		mdl.mem[36'h10004] = 64'h0002_0001;
		mdl.mem[36'h20004] = 64'h0003_3001;
		mdl.mem[36'h10008] = 64'h00c0_2081;
		mdl.mem[36'hc02004] = 64'h0005_5001;
		mdl.mem[36'h10010] = 64'h0004_0001;
		mdl.mem[36'h40018] = 64'h2_0060_0081;
		mdl.mem[36'h40010] = 64'h0005_0001;
		mdl.mem[36'h50000] = 64'h8_0007_0001;
		rows = '{'{EN, 0, 32'h0040_1abc, 36'h3_3abc, 1, 0},
			'{EN, 32'h10, 32'h0040_1abc, 36'h3_3abc, 1, 0},
			'{EN, 32'h10, 32'h0080_1234, 36'h1_00c0_1234, 3, 0},
			'{EN, 0, 32'h0080_1234, 36'h5_5234, 1, 0},
			'{EN, 32'h10, 32'h00c0_0000, 0, 0, 1},
			'{EN, 0, 32'h0040_2000, 0, 0, 1},
			'{0, 32'h30, 32'hdead_beef, 36'hdead_beef, 0, 0},
			'{EN, 32'h20, 32'h8060_0555, 36'h2_0060_0555, 2, 0},
			'{EN, 32'h30, 32'h8060_0555, 36'h2_0060_0555, 2, 0},
			'{EN, 32'h20, 32'h8040_0123, 36'h8_0007_0123, 1, 0}};
		repeat (3) @(posedge sys_clk);
		rst_b <= 1'b1;
		apb(0, `LPT_OFS_CTLZERO, 0, 4'hf);
		chk(rd, 0);
		apb(0, `LPT_OFS_CTLFOUR, 0, 4'hf);
		chk(rd, 0);
		apb(1, `LPT_OFS_FEATURE, 0, 4'hf);
		apb(0, `LPT_OFS_FEATURE, 0, 4'hf);
		chk(rd[17], 1);
		apb(0, 8'h20, 0, 4'hf);
		chk({err, rd}, {1'b1, 32'h0});
		apb(1, `LPT_OFS_CTLZERO, 32'hffff_ffff, 4'h7);
		apb(0, `LPT_OFS_CTLZERO, 0, 4'hf);
		chk(rd, 0);
		apb(1, `LPT_OFS_CTLZERO, 32'hffff_ffff, 4'hf);
		apb(0, `LPT_OFS_CTLZERO, 0, 4'hf);
		chk(rd, EN);
		apb(1, `LPT_OFS_CTLFOUR, 32'hff, 4'h1);
		apb(0, `LPT_OFS_CTLFOUR, 0, 4'hf);
		chk(rd, 32'h30);
		apb(0, `LPT_OFS_STATUS, 0, 4'hf);
		chk(rd[5:4], 2'b11);
		apb(1, `LPT_OFS_DIRLO, 32'h1_0000, 4'hf);
		apb(1, `LPT_OFS_DIRHI, 0, 4'hf);
		foreach (rows[i]) begin
			apb(1, `LPT_OFS_CTLZERO, rows[i].c0, 4'hf);
			apb(1, `LPT_OFS_CTLFOUR, rows[i].c4, 4'hf);
			xlate(rows[i].lin);
			chk({respFault, respSize}, {rows[i].f, rows[i].sz});
			chk(respPhys, rows[i].ph);
			apb(0, `LPT_OFS_PHYSLO, 0, 4'hf);
			chk(rd, rows[i].ph[31:0]);
		end
		// slow table memory on a two-level walk
		memDelay <= 8'h5;
		apb(1, `LPT_OFS_CTLZERO, EN, 4'hf);
		apb(1, `LPT_OFS_CTLFOUR, 0, 4'hf);
		xlate(32'h0040_1abc);
		chk(respPhys, 36'h3_3abc);
		// second reset in mid-run clears control state
		@(posedge sys_clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge sys_clk);
		chk(reqReady, 0);
		rst_b <= 1'b1;
		apb(0, `LPT_OFS_CTLZERO, 0, 4'hf);
		chk(rd, 0);
		xlate(32'h1234_5678);
		chk(64'({respSize, respPhys}), 64'({2'h0, 36'h1234_5678}));
		// low clock enable freezes the core with a request pending
		ce <= 1'b0;
		reqValid <= 1'b1;
		reqLinear <= 32'h0000_0042;
		repeat (3) @(posedge sys_clk);
		chk(respPhys, 36'h0_1234_5678);
		ce <= 1'b1;
		reqValid <= 1'b0;
		xlate(32'h0000_0042);
		chk(respPhys, 36'h0_0000_0042);
		results();
	end

	initial begin
		#2_000_000;
		mismatches++;
		results();
	end
endmodule
